/* verilog/cpsd_pkg.sv */
// package: constants for the coprocessor-space access decode
package cpsd_pkg;
    localparam logic [2:0]  CPSD_SPACE_CPU      = 3'h7;
    localparam logic [2:0]  CPSD_SPACE_UDATA    = 3'h1;
    localparam logic [3:0]  CPSD_TYPE_IACK      = 4'hF;
    localparam logic [3:0]  CPSD_TYPE_BKPT      = 4'h0;
    localparam logic [3:0]  CPSD_TYPE_MODULE    = 4'h1;
    localparam logic [3:0]  CPSD_TYPE_COPROC    = 4'h2;
    localparam int          CPSD_TYPE_LSB       = 16;
    localparam int          CPSD_SEL_LSB        = 13;
    localparam int          CPSD_OPW_SEL_LSB    = 9;
    localparam int          CPSD_OPW_CAT_LSB    = 6;
    // interface register offsets inside the coprocessor region
    localparam logic [4:0]  CPSD_REG_RESPONSE   = 5'h00;
    localparam logic [4:0]  CPSD_REG_SAVE       = 5'h04;
    localparam logic [4:0]  CPSD_REG_RESTORE    = 5'h06;
    localparam logic [4:0]  CPSD_REG_COMMAND    = 5'h0A;
    localparam logic [4:0]  CPSD_REG_CONDITION  = 5'h0E;
    localparam logic [4:0]  CPSD_REG_OPERAND    = 5'h10;
    // instruction categories from operation word bits 8..6
    localparam logic [2:0]  CPSD_CAT_GENERAL    = 3'h0;
    localparam logic [2:0]  CPSD_CAT_COND       = 3'h1;
    localparam logic [2:0]  CPSD_CAT_SAVE       = 3'h4;
    localparam logic [2:0]  CPSD_CAT_RESTORE    = 3'h5;
    localparam logic [15:0] CPSD_RESP_RELEASE   = 16'h0802;
    localparam logic [15:0] CPSD_RESP_RESET     = 16'h0802;
    localparam logic [2:0]  CPSD_SEL_DEFAULT    = 3'h1;
endpackage

/* verilog/cpsd_bus_if.sv */
// interface: asynchronous processor bus between processor and coprocessor
`timescale 1ns/1ps
`default_nettype none
interface cpsd_bus_if;
    logic [31:0] addr;
    logic [2:0]  access_space_code;
    logic        as_n;
    logic        rw;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        dsack_n;
    modport proc (output addr, access_space_code, as_n, rw, wdata, input rdata, dsack_n);
    modport copr (input addr, access_space_code, as_n, rw, wdata, output rdata, dsack_n);
endinterface
`default_nettype wire

/* verilog/cpsd_proc_end.sv */
// module: processor end, issues coprocessor and operand bus cycles
//
// Behaviour
// RULE_01: coprocessor cycles drive space code 111
// RULE_02: processor-space cycle type sits on A19..A16
// RULE_03: coprocessor access uses type 0010
// RULE_04: select code from opword 11..9 onto A15..A13
// RULE_05: all other address bits driven zero
// RULE_06: coprocessor decodes space code and A19..A13
// RULE_07: eight select codes, each unique per coprocessor
// RULE_08: A4..A0 select the interface register
// RULE_09: asynchronous handshake, strobe held until acknowledge
// RULE_10: operand out: read register, write memory
// RULE_11: operand in: read memory, write register
// RULE_12: bus-master coprocessor still slaves for processor
// RULE_13: four categories pick the starting register
// RULE_14: general/conditional status by response primitives
// RULE_15: save/restore status by format codes
// RULE_16: register set starts instructions, carries operands
// RULE_17: never issue select code zero
// RULE_18: general: write command, then read response
// RULE_19: coprocessor ignores other types and codes
`timescale 1ns/1ps
`default_nettype none
module cpsd_proc_end
    import cpsd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    cpsd_bus_if.proc         bus,
    input  wire logic        start,
    input  wire logic [1:0]  op,
    input  wire logic [15:0] opword,
    input  wire logic [15:0] cmd_word,
    input  wire logic [31:0] ea_addr,
    input  wire logic [2:0]  ea_space,
    input  wire logic [31:0] ea_wdata,
    output logic             busy,
    output logic             done,
    output logic             err,
    output logic [31:0]      result
);
    // op: 0 start instruction, 1 operand out, 2 operand in
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CYC1  = 3'b001,
        S_WAIT1 = 3'b010,
        S_CYC2  = 3'b011,
        S_WAIT2 = 3'b100,
        S_DONE  = 3'b101
    } cpsd_state_t;

    cpsd_state_t  state_reg;
    logic [1:0]   op_reg;
    logic [2:0]   sel_reg;
    logic [4:0]   reg1_reg;
    logic [4:0]   reg2_reg;
    logic [15:0]  cmd_reg;
    logic [31:0]  ea_reg;
    logic [2:0]   eas_reg;
    logic [31:0]  data_reg;
    logic [2:0]   cat;
    logic [4:0]   first_reg_next;

    // ========================================
    // category decode
    assign cat = opword[CPSD_OPW_CAT_LSB +: 3];

    always_comb
    begin
        case (cat) // see RULE_13
            CPSD_CAT_GENERAL: first_reg_next = CPSD_REG_COMMAND;   // see RULE_18
            CPSD_CAT_COND:    first_reg_next = CPSD_REG_CONDITION;
            CPSD_CAT_SAVE:    first_reg_next = CPSD_REG_SAVE;
            CPSD_CAT_RESTORE: first_reg_next = CPSD_REG_RESTORE;
            default:          first_reg_next = CPSD_REG_COMMAND;
        endcase
    end

    // builds a coprocessor-space address
    function automatic logic [31:0] cp_addr(input logic [2:0] sel, input logic [4:0] r);
        logic [31:0] a;
        a = 32'h0000_0000; // see RULE_05
        a[CPSD_TYPE_LSB +: 4] = CPSD_TYPE_COPROC; // see RULE_02, RULE_03
        a[CPSD_SEL_LSB +: 3] = sel; // see RULE_04
        a[4:0] = r; // see RULE_08
        return a;
    endfunction

    // ========================================
    // sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= S_IDLE;
            op_reg    <= 2'h0;
            sel_reg   <= 3'h0;
            reg1_reg  <= 5'h00;
            reg2_reg  <= 5'h00;
            cmd_reg   <= 16'h0000;
            ea_reg    <= 32'h0000_0000;
            eas_reg   <= 3'h0;
            data_reg  <= 32'h0000_0000;
            busy      <= 1'b0;
            done      <= 1'b0;
            err       <= 1'b0;
            result    <= 32'h0000_0000;
            bus.addr  <= 32'h0000_0000;
            bus.access_space_code <= 3'h0;
            bus.as_n  <= 1'b1;
            bus.rw    <= 1'b1;
            bus.wdata <= 32'h0000_0000;
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    err <= 1'b0;
                    if (start)
                    begin
                        if (opword[CPSD_OPW_SEL_LSB +: 3] == 3'h0 || op == 2'h3)
                        begin
                            err  <= 1'b1; // see RULE_17
                            done <= 1'b1;
                        end
                        else
                        begin
                            op_reg   <= op;
                            sel_reg  <= opword[CPSD_OPW_SEL_LSB +: 3];
                            reg1_reg <= (op == 2'h0) ? first_reg_next : CPSD_REG_OPERAND;
                            reg2_reg <= CPSD_REG_RESPONSE;
                            cmd_reg  <= cmd_word;
                            ea_reg   <= ea_addr;
                            eas_reg  <= ea_space;
                            data_reg <= ea_wdata;
                            busy     <= 1'b1;
                            state_reg <= S_CYC1;
                        end
                    end
                end
                S_CYC1:
                begin
                    bus.as_n <= 1'b0;
                    if (op_reg == 2'h2)
                    begin
                        // operand in: memory read first, see RULE_11
                        bus.addr <= ea_reg;
                        bus.access_space_code <= eas_reg;
                        bus.rw   <= 1'b1;
                    end
                    else
                    begin
                        bus.addr <= cp_addr(sel_reg, reg1_reg); // see RULE_16
                        bus.access_space_code <= CPSD_SPACE_CPU; // see RULE_01
                        bus.rw   <= (op_reg == 2'h1); // see RULE_10
                        bus.wdata <= {cmd_reg, 16'h0000};
                    end
                    state_reg <= S_WAIT1;
                end
                S_WAIT1:
                begin
                    if (!bus.dsack_n) // see RULE_09
                    begin
                        bus.as_n <= 1'b1;
                        if (op_reg != 2'h0)
                            data_reg <= bus.rdata;
                        state_reg <= S_CYC2;
                    end
                end
                S_CYC2:
                begin
                    if (bus.dsack_n)
                    begin
                        bus.as_n <= 1'b0;
                        bus.wdata <= data_reg;
                        if (op_reg == 2'h1)
                        begin
                            bus.addr <= ea_reg; // see RULE_10
                            bus.access_space_code <= eas_reg;
                            bus.rw   <= 1'b0;
                        end
                        else
                        begin
                            bus.addr <= cp_addr(sel_reg,
                                (op_reg == 2'h2) ? CPSD_REG_OPERAND : reg2_reg); // see RULE_11
                            bus.access_space_code <= CPSD_SPACE_CPU;
                            bus.rw   <= (op_reg == 2'h0); // see RULE_18
                        end
                        state_reg <= S_WAIT2;
                    end
                end
                S_WAIT2:
                begin
                    if (!bus.dsack_n)
                    begin
                        bus.as_n <= 1'b1;
                        if (op_reg == 2'h0)
                            result <= bus.rdata; // see RULE_14, RULE_15
                        else
                            result <= data_reg;
                        state_reg <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    if (bus.dsack_n)
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        bus.addr <= 32'h0000_0000;
                        bus.access_space_code <= 3'h0;
                        bus.rw <= 1'b1;
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // cpsd_proc_end
`default_nettype wire

/* verilog/cpsd_copr_end.sv */
// module: coprocessor end, decodes its chip select and serves the register set
`timescale 1ns/1ps
`default_nettype none
module cpsd_copr_end
    import cpsd_pkg::*;
#(
    parameter logic [2:0] SEL_CODE = CPSD_SEL_DEFAULT
)(
    input  wire logic        clk,
    input  wire logic        rst_n,
    cpsd_bus_if.copr         bus,
    input  wire logic [15:0] status_word,
    input  wire logic [31:0] operand_out,
    output logic             cmd_valid,
    output logic [4:0]       cmd_reg_sel,
    output logic [15:0]      cmd_data,
    output logic             opnd_valid,
    output logic [31:0]      opnd_data
);
    logic hit;
    logic ack_reg;

    // ========================================
    // chip select: space code, type and own select code
    assign hit = !bus.as_n && bus.access_space_code == CPSD_SPACE_CPU
              && bus.addr[CPSD_TYPE_LSB +: 4] == CPSD_TYPE_COPROC
              && bus.addr[CPSD_SEL_LSB +: 3] == SEL_CODE; // see RULE_06, RULE_07, RULE_19

    // ========================================
    // slave handshake: acknowledge held until strobe negates
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack_reg     <= 1'b0;
            bus.dsack_n <= 1'b1;
            bus.rdata   <= 32'h0000_0000;
            cmd_valid   <= 1'b0;
            cmd_reg_sel <= 5'h00;
            cmd_data    <= 16'h0000;
            opnd_valid  <= 1'b0;
            opnd_data   <= 32'h0000_0000;
        end
        else
        begin
            cmd_valid  <= 1'b0;
            opnd_valid <= 1'b0;
            if (bus.as_n)
            begin
                ack_reg     <= 1'b0;
                bus.dsack_n <= 1'b1; // see RULE_09
            end
            else if (hit && !ack_reg)
            begin
                ack_reg     <= 1'b1;
                bus.dsack_n <= 1'b0; // see RULE_12
                if (bus.rw)
                    bus.rdata <= (bus.addr[4:0] == CPSD_REG_OPERAND) ? operand_out
                               : {status_word, 16'h0000}; // see RULE_14, RULE_15
                else if (bus.addr[4:0] == CPSD_REG_OPERAND)
                begin
                    opnd_valid <= 1'b1;
                    opnd_data  <= bus.wdata;
                end
                else
                begin
                    cmd_valid   <= 1'b1; // see RULE_16
                    cmd_reg_sel <= bus.addr[4:0];
                    cmd_data    <= bus.wdata[31:16];
                end
            end
        end
    end
endmodule // cpsd_copr_end
`default_nettype wire

/* verif/cpsd_chk.sv */
// checker: timing and address encoding of cycles on the coprocessor bus
`timescale 1ns/1ps
`default_nettype none
module cpsd_chk
    import cpsd_pkg::*;
#(
    parameter logic [2:0] SEL_CODE = CPSD_SEL_DEFAULT
)(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [31:0] addr,
    input wire logic [2:0]  access_space_code,
    input wire logic        as_n,
    input wire logic        rw,
    input wire logic        dsack_n
);
    wire logic cp_cyc = !as_n && access_space_code == CPSD_SPACE_CPU;
    wire logic hit    = cp_cyc && addr[19:13] == {CPSD_TYPE_COPROC, SEL_CODE};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // address encoding
    a_space_type: assert property (
        cp_cyc |-> addr[19:16] == CPSD_TYPE_COPROC) else $error("wrong cpu space type");
    a_addr_zero: assert property (
        cp_cyc |-> addr[31:20] == 12'h000 && addr[12:5] == 8'h00) else $error("address not zero");
    a_sel_nonzero: assert property (
        cp_cyc |-> addr[15:13] != 3'h0) else $error("select code zero issued");
    a_resp_read: assert property (
        cp_cyc && addr[4:0] == CPSD_REG_RESPONSE |-> rw) else $error("response written");
    // ==========================================================
    // handshake
    a_req_hold: assert property (
        !as_n && dsack_n |=> !as_n && $stable(addr) && $stable(rw)) else $error("request dropped");
    a_ack_prompt: assert property (
        $fell(as_n) && hit |=> !dsack_n) else $error("no acknowledge");
    a_no_foreign: assert property (
        $fell(dsack_n) |-> $past(hit)) else $error("acknowledge without select");
    a_ack_release: assert property (
        !dsack_n && as_n |=> dsack_n) else $error("acknowledge held");
    a_strobe_end: assert property (
        !dsack_n && !as_n |=> as_n) else $error("strobe held after acknowledge");
    c_cp_write: cover property (hit && !rw);
    c_cp_read: cover property (hit && rw);
    c_ack: cover property ($fell(dsack_n));
    c_foreign: cover property (cp_cyc && !hit);
endmodule // cpsd_chk
`default_nettype wire

/* verif/testbench.sv */
// testbench: processor end and coprocessor end joined on one bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpsd_pkg::*;
    logic        clk, rst_n, start, busy, done, err, cmd_valid, opnd_valid, prev_as;
    logic [1:0]  op;
    logic [2:0]  ea_space, cats [4];
    logic [4:0]  cmd_reg_sel, c_sel;
    logic [15:0] opword, cmd_word, status_word, cmd_data, c_dat;
    logic [31:0] ea_addr, ea_wdata, operand_out, result, opnd_data, o_dat, seed;
    logic [5:0]  log_q [$];
    int          n_mismatch, checks_done, cycles, n_cmd, n_opnd;
    cpsd_bus_if bus ();
    cpsd_proc_end cpsd_proc_end_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .start(start),
        .op(op), .opword(opword), .cmd_word(cmd_word), .ea_addr(ea_addr), .ea_space(ea_space),
        .ea_wdata(ea_wdata), .busy(busy), .done(done), .err(err), .result(result));
    cpsd_copr_end cpsd_copr_end_inst (.clk(clk), .rst_n(rst_n), .bus(bus),
        .status_word(status_word), .operand_out(operand_out), .cmd_valid(cmd_valid),
        .cmd_reg_sel(cmd_reg_sel), .cmd_data(cmd_data), .opnd_valid(opnd_valid),
        .opnd_data(opnd_data));
    cpsd_chk cpsd_chk_inst (.clk(clk), .rst_n(rst_n), .addr(bus.addr),
        .access_space_code(bus.access_space_code), .as_n(bus.as_n), .rw(bus.rw),
        .dsack_n(bus.dsack_n));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'hA3000000 : 32'h00000000);
    endfunction
    function automatic logic [4:0] cat_reg(input logic [2:0] c);
        case (c)
            CPSD_CAT_COND:    return CPSD_REG_CONDITION;
            CPSD_CAT_SAVE:    return CPSD_REG_SAVE;
            CPSD_CAT_RESTORE: return CPSD_REG_RESTORE;
            default:          return CPSD_REG_COMMAND;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one instruction step, then compare bus cycles and coprocessor events
    task automatic run(input logic [1:0] o, input logic [2:0] sel, input logic [2:0] cat);
        int i;
        int nc;
        int no;
        logic [4:0] r;
        nc = n_cmd;
        no = n_opnd;
        r = (o == 2'd1) ? CPSD_REG_COMMAND : CPSD_REG_OPERAND;
        log_q.delete();
        seed = lfsr(seed);
        op = o;
        opword = {4'hF, sel, cat, 6'h00};
        cmd_word = seed[15:0];
        status_word = seed[31:16];
        operand_out = ~seed;
        ea_wdata = seed;
        ea_space = CPSD_SPACE_CPU;
        ea_addr = {12'h000, CPSD_TYPE_COPROC, CPSD_SEL_DEFAULT, 8'h00, r};
        start = 1'b1;
        @(posedge clk) #1;
        start = 1'b0;
        for (i = 0; i < 40 && done !== 1'b1; i++)
            @(posedge clk) #1;
        chk(done, 1'b1);
        chk(busy, 1'b0);
        if (sel == 3'h0 || o == 2'd3)
        begin
            chk(err, 1'b1);
            chk(log_q.size(), 0);
            return;
        end
        chk(err, 1'b0);
        chk(log_q.size(), 2);
        if (o == 2'd0)
        begin
            chk(log_q[0], {1'b0, cat_reg(cat)});
            chk(log_q[1], {1'b1, CPSD_REG_RESPONSE});
            chk({c_sel, c_dat}, {cat_reg(cat), cmd_word});
            chk(result, {status_word, 16'h0000});
        end
        else
        begin
            chk(log_q[0], {1'b1, CPSD_REG_OPERAND});
            chk(log_q[1], {1'b0, r});
            if (o == 2'd1)
                chk({c_sel, c_dat}, {r, operand_out[31:16]});
            else
                chk(o_dat, operand_out);
            chk(result, operand_out);
        end
        chk(n_cmd - nc, (o == 2'd2) ? 0 : 1);
        chk(n_opnd - no, (o == 2'd2) ? 1 : 0);
    endtask
    // a foreign select code gets no acknowledge; a mid-run reset frees the bus
    task automatic foreign(input logic [2:0] sel);
        int nx;
        nx = n_cmd + n_opnd;
        op = 2'd0;
        opword = {4'hF, sel, CPSD_CAT_GENERAL, 6'h00};
        start = 1'b1;
        @(posedge clk) #1;
        start = 1'b0;
        repeat (12) @(posedge clk) #1;
        chk(bus.as_n, 1'b0);
        chk(bus.dsack_n, 1'b1);
        chk(busy, 1'b1);
        chk(n_cmd + n_opnd - nx, 0);
        rst_n = 1'b0;
        @(posedge clk) #1;
        rst_n = 1'b1;
        chk(bus.as_n, 1'b1);
        chk(bus.dsack_n, 1'b1);
        chk(busy, 1'b0);
    endtask
    // ==========================================================
    // clock, monitor, timeout and sequence
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always
    begin
        @(posedge clk) #1;
        cycles++;
        if (rst_n && bus.as_n === 1'b0 && prev_as === 1'b1)
            log_q.push_back({bus.rw, bus.addr[4:0]});
        prev_as = bus.as_n;
        if (cmd_valid === 1'b1)
        begin
            c_sel = cmd_reg_sel;
            c_dat = cmd_data;
            n_cmd++;
        end
        if (opnd_valid === 1'b1)
        begin
            o_dat = opnd_data;
            n_opnd++;
        end
        if (cycles == 5000)
        begin
            n_mismatch++;
            conclude();
        end
    end
    initial
    begin
        cats = '{CPSD_CAT_GENERAL, CPSD_CAT_COND, CPSD_CAT_SAVE, CPSD_CAT_RESTORE};
        {rst_n, start, op, opword, cmd_word, ea_addr, ea_space} = '0;
        {ea_wdata, status_word, operand_out, prev_as} = '0;
        seed = 32'hC4F4;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int k = 0; k < 4; k++)
            run(2'd0, CPSD_SEL_DEFAULT, cats[k]);
        run(2'd0, 3'h0, CPSD_CAT_GENERAL);
        run(2'd3, CPSD_SEL_DEFAULT, CPSD_CAT_GENERAL);
        run(2'd1, CPSD_SEL_DEFAULT, CPSD_CAT_GENERAL);
        run(2'd2, CPSD_SEL_DEFAULT, CPSD_CAT_GENERAL);
        foreign(3'h6);
        run(2'd0, CPSD_SEL_DEFAULT, CPSD_CAT_SAVE);
        repeat (10)
        begin
            seed = lfsr(seed);
            run((seed[1:0] == 2'd3) ? 2'd0 : seed[1:0], CPSD_SEL_DEFAULT, cats[seed[3:2]]);
        end
        conclude();
    end
endmodule // testbench
`default_nettype wire
